/* rtl/ntt_pkg.sv */
// Purpose: Shared constants and types of the NAND tree test block
// Assumes: 100 MHz ref_clk
// Notes:   Mode decode itself is combinational
package ntt_pkg;

  // Active level of the test qualifier and the chain-mode and float-mode selects
  localparam logic NTT_QUAL_ACTIVE = 1'h0;  // Qualifier low enables tests
  localparam logic NTT_SEL_NAND    = 1'h0;  // Select level for chain mode
  localparam logic NTT_SEL_FLOAT   = 1'h1;  // Select level for float mode

  // Pad counts of the two chain sections
  localparam int NTT_SEC1_PINS = 16;        // Plain pins ahead of mid tap
  localparam int NTT_SEC2_PINS = 16;        // Plain pins after mid tap
  localparam int NTT_IRQ_PINS  = 10;        // Other inverting request pins

  // Propagation allowance the tester waits before sampling
  localparam int NTT_CLK_PERIOD_NS = 10;    // Clock period
  localparam int NTT_SETTLE_NS     = 500;   // Input to chain output allowance
  localparam int NTT_SETTLE_CYC    =
    (NTT_SETTLE_NS + NTT_CLK_PERIOD_NS - 1) / NTT_CLK_PERIOD_NS;

  // Value of the mode status register after reset
  localparam logic [1:0] NTT_MODE_RESET = 2'h0;

  // Test mode of the pad ring
  typedef enum logic [1:0]
  {
    NTT_MODE_NORMAL,
    NTT_MODE_NAND,
    NTT_MODE_FLOAT
  } ntt_mode_t;

endpackage : ntt_pkg

/* rtl/ntt_sec_if.sv */
// Purpose: Carrier between the top and one NAND chain section
// Assumes: Purely combinational signals
// Notes:   One instance per chain section
`timescale 1ns/1ps
`default_nettype none
interface ntt_sec_if #(parameter int WIDTH = 4);
  logic [WIDTH-1:0] pins;    // Chained pad levels, already normalised
  logic             seed;    // Result of the preceding section, tied high for the first section
  logic             result;  // Output of the last NAND of this section

  // Side feeding the section
  modport src (output pins, output seed, input result);
  // The section itself
  modport sec (input pins, input seed, output result);
endinterface : ntt_sec_if
`default_nettype wire

/* rtl/ntt_nand_section.sv */
// Purpose: One section of the NAND chain
// Assumes: All pins idle high after normalisation
// Notes:   With seed high and pins idle, only a toggle on an even-index pin reaches the result
`timescale 1ns/1ps
`default_nettype none
module ntt_nand_section #(
  parameter int WIDTH = 4               // Number of chained pins
)(
  ntt_sec_if.sec bus                    // Pins, seed and result
);

  logic [WIDTH-1:0] stage;              // Output of each NAND gate

  // First gate combines the seed, then each gate the previous stage
  assign stage[0] = ~(bus.seed & bus.pins[0]);

  genvar g;
  generate
    for (g = 1; g < WIDTH; g++)
    begin : g_chain
      // Ripple stage
      assign stage[g] = ~(stage[g-1] & bus.pins[g]);
    end
  endgenerate

  // Last gate is the section output
  assign bus.result = stage[WIDTH-1];

endmodule : ntt_nand_section
`default_nettype wire

/* rtl/ntt_nand_tree_test.sv */
// Purpose: NAND tree and float-all test logic of the pad ring
// Assumes: Tester holds the mode pins steady for a whole test
// Notes:   Mode decode and chain are asynchronous, status is clocked
// Function
// R1: Qualifier low plus select a or c low
// R2: Chain mode floats pads, chains them as inputs
// R3: DMA acknowledge-1 pad is the mid-chain output
// R4: Transceiver direction pad drives final chain result
// R5: Request, power-good, zero-wait pads enter inverted
// R6: PCI bus clock stays out of chain
// R7: Tester waits allowance before sampling chain outputs
// R8: Qualifier low, all selects high: float mode
// R9: Float mode tri-states every pad, both observers
`timescale 1ns/1ps
`default_nettype none
module ntt_nand_tree_test
  import ntt_pkg::*;
#(
  parameter int SEC1_PINS = NTT_SEC1_PINS,   // Plain pins of first section
  parameter int SEC2_PINS = NTT_SEC2_PINS,   // Plain pins of second section
  parameter int IRQ_PINS  = NTT_IRQ_PINS     // Other request pins
)(
  input  wire logic                 ref_clk,
  input  wire logic                 rstn,
  input  wire logic                 test_qualifier_n,
  input  wire logic                 mode_select_a,
  input  wire logic                 mode_select_b,
  input  wire logic                 mode_select_c,
  input  wire logic                 power_good_in,
  input  wire logic                 zero_wait_state_in_n,
  input  wire logic [IRQ_PINS-1:0]  irq_in,
  input  wire logic                 pci_bus_clock_in,
  input  wire logic [SEC1_PINS+SEC2_PINS-1:0] pad_in,
  input  wire logic [SEC1_PINS+SEC2_PINS-1:0] func_pad_oe,
  input  wire logic                 func_dma_ack1_mid_chain_out_out,
  input  wire logic                 func_dma_ack1_mid_chain_out_oe,
  input  wire logic                 func_transceiver_dir_final_out_out,
  input  wire logic                 func_transceiver_dir_final_out_oe,
  output logic [SEC1_PINS+SEC2_PINS-1:0] pad_oe,
  output logic                      dma_ack1_mid_chain_out,
  output logic                      dma_ack1_oe,
  output logic                      transceiver_dir_final_out,
  output logic                      transceiver_dir_oe,
  output logic                      clk_path_active,
  output ntt_mode_t                 mode_status
);

  localparam int PADS = SEC1_PINS + SEC2_PINS;   // All plain chained pads
  localparam int W1   = SEC1_PINS + 4;           // Section 1 incl. inverted
  localparam int W2   = SEC2_PINS + IRQ_PINS + 1;// Section 2 incl. inverted

  logic      qual_on;           // Test qualifier active
  logic      nand_on;           // Chain mode decoded
  logic      float_on;          // Float-all mode decoded
  ntt_mode_t mode_reg;          // Registered mode for status
  ntt_mode_t mode_next;         // Next registered mode

  ntt_sec_if #(.WIDTH(W1)) sec1 ();   // First section, ends mid-chain
  ntt_sec_if #(.WIDTH(W2)) sec2 ();   // Second section, ends at final pad

  // Asynchronous mode decode straight from the pads
  always_comb
  begin
    qual_on  = (test_qualifier_n == NTT_QUAL_ACTIVE);
    nand_on  = qual_on && ((mode_select_a == NTT_SEL_NAND) ||
                           (mode_select_c == NTT_SEL_NAND)); // see R1
    float_on = qual_on && (mode_select_a == NTT_SEL_FLOAT) &&
               (mode_select_b == NTT_SEL_FLOAT) &&
               (mode_select_c == NTT_SEL_FLOAT);             // see R8
  end

  // Chain inputs: inverting pads flipped so idle low reads high
  // A pad toggle only reaches an observer while every later chained
  // input sits at its idle level, so the tester walks one pad at a time
  always_comb
  begin
    sec1.seed = 1'h1;                                        // Chain head
    sec1.pins = {~mode_select_c, ~mode_select_b, ~mode_select_a,
                 ~zero_wait_state_in_n,
                 pad_in[SEC1_PINS-1:0]};                     // see R5
    sec2.seed = sec1.result;                                 // see R4
    sec2.pins = {~power_good_in, ~irq_in,
                 pad_in[PADS-1:SEC1_PINS]};                  // see R5
  end

  // Clock pad feeds functional logic only, never the chain
  assign clk_path_active = pci_bus_clock_in & ~nand_on;      // see R6

  // Chain sections
  ntt_nand_section #(.WIDTH(W1)) u_sec1 (.bus(sec1.sec));
  ntt_nand_section #(.WIDTH(W2)) u_sec2 (.bus(sec2.sec));

  // Pad ring enables and observer pads
  always_comb
  begin
    if (float_on)
    begin
      // Everything floats, observers too
      pad_oe                    = '0;                        // see R9
      dma_ack1_mid_chain_out    = 1'h0;
      dma_ack1_oe               = 1'h0;                      // see R9
      transceiver_dir_final_out = 1'h0;
      transceiver_dir_oe        = 1'h0;                      // see R9
    end
    else if (nand_on)
    begin
      // Pads become chain inputs, observers drive the chain
      pad_oe                    = '0;                        // see R2
      dma_ack1_mid_chain_out    = sec1.result;               // see R3
      dma_ack1_oe               = 1'h1;                      // see R3
      transceiver_dir_final_out = sec2.result;               // see R4
      transceiver_dir_oe        = 1'h1;                      // see R4
    end
    else
    begin
      // Normal operation
      pad_oe                    = func_pad_oe;
      dma_ack1_mid_chain_out    = func_dma_ack1_mid_chain_out_out;
      dma_ack1_oe               = func_dma_ack1_mid_chain_out_oe;
      transceiver_dir_final_out = func_transceiver_dir_final_out_out;
      transceiver_dir_oe        = func_transceiver_dir_final_out_oe;
    end
  end

  // Next registered mode; float wins if both decoded
  always_comb
  begin
    if (float_on)
      mode_next = NTT_MODE_FLOAT;
    else if (nand_on)
      mode_next = NTT_MODE_NAND;
    else
      mode_next = NTT_MODE_NORMAL;
  end

  // Mode status register
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      mode_reg <= ntt_mode_t'(NTT_MODE_RESET);
    else
      mode_reg <= mode_next;
  end

  assign mode_status = mode_reg;

  // Chain mode decode tracked by status one cycle on
  AST_NAND_DECODE: assert property (@(posedge ref_clk)  // see R1
    disable iff (!rstn)
    (!test_qualifier_n && (!mode_select_a || !mode_select_c) &&
     !(mode_select_a && mode_select_b && mode_select_c))
    |=> (mode_status == NTT_MODE_NAND))
    else $error("chain mode not reported");

  // Select c low alone is enough for chain mode
  AST_NAND_SELECT_C: assert property (@(posedge ref_clk)  // see R1
    disable iff (!rstn)
    (!test_qualifier_n && !mode_select_c) |-> nand_on)
    else $error("second chain select ignored");

  // Chain mode floats every plain pad
  AST_NAND_FLOAT_PADS: assert property (@(posedge ref_clk)  // see R2
    disable iff (!rstn)
    (nand_on && !float_on) |-> (pad_oe == '0) && dma_ack1_oe &&
    transceiver_dir_oe)
    else $error("pad driven in chain mode");

  // Mid-chain pad shows section one result
  AST_MID_TAP: assert property (@(posedge ref_clk)  // see R3
    disable iff (!rstn)
    (nand_on && !float_on) |->
    (dma_ack1_mid_chain_out == sec1.result))
    else $error("mid-chain output wrong");

  // Idle second section hands every mid-chain toggle to the final pad
  AST_FINAL_TOGGLE: assert property (@(posedge ref_clk)  // see R4
    disable iff (!rstn)
    (nand_on && $stable(nand_on) && (&sec2.pins) && $stable(sec2.pins) &&
     $changed(dma_ack1_mid_chain_out))
    |-> $changed(transceiver_dir_final_out))
    else $error("final output missed a chain toggle");

  // Idle request and power-good pads at zero read high inside the chain
  AST_INVERT_IDLE: assert property (@(posedge ref_clk)  // see R5
    disable iff (!rstn)
    (!power_good_in && (irq_in == '0)) |->
    (sec2.pins[W2-1:SEC2_PINS] == '1))
    else $error("inverting pad not inverted");

  // Idle select and zero-wait pads read high in the first section
  AST_INVERT_IDLE_S1: assert property (@(posedge ref_clk)  // see R5
    disable iff (!rstn)
    (!mode_select_a && !mode_select_b && !mode_select_c &&
     !zero_wait_state_in_n) |->
    (sec1.pins[W1-1:SEC1_PINS] == '1))
    else $error("select or zero-wait pad not inverted");

  // Clock pad has no effect on chain outputs
  AST_CLK_EXCLUDED: assert property (@(posedge ref_clk)  // see R6
    disable iff (!rstn)
    (nand_on && $stable(pad_in) && $stable(irq_in) &&
     $changed(pci_bus_clock_in) && $stable(sec2.pins) && $stable(sec1.pins))
    |-> $stable(transceiver_dir_final_out))
    else $error("clock pad leaks into chain");

  // Clock path closed whenever the chain is selected
  AST_CLK_GATED: assert property (@(posedge ref_clk)  // see R6
    disable iff (!rstn)
    nand_on |-> !clk_path_active)
    else $error("clock path open in chain mode");

  // Float decode tracked by status one cycle on
  AST_FLOAT_DECODE: assert property (@(posedge ref_clk)  // see R8
    disable iff (!rstn)
    (!test_qualifier_n && mode_select_a && mode_select_b && mode_select_c)
    |=> (mode_status == NTT_MODE_FLOAT))
    else $error("float mode not reported");

  // Float mode releases every pad including observers
  AST_FLOAT_ALL: assert property (@(posedge ref_clk)  // see R9
    disable iff (!rstn)
    float_on |->
    (pad_oe == '0) && !dma_ack1_oe && !transceiver_dir_oe)
    else $error("pad driven in float mode");

endmodule : ntt_nand_tree_test
`default_nettype wire

/* dv/ntt_ate_model.sv */
// Purpose: Board tester model driving the chained and mode pads
// Assumes: Pins change 1 ns after a rising edge of ref_clk
// Notes:   Levels hold until the next call changes them
`timescale 1ns/1ps
`default_nettype none
module ntt_ate_model
  import ntt_pkg::*;
(
  input  wire logic ref_clk,
  output logic      test_qualifier_n,
  output logic      mode_select_a,
  output logic      mode_select_b,
  output logic      mode_select_c,
  output logic      pci_bus_clock_in,
  output logic [NTT_SEC1_PINS+NTT_SEC2_PINS+NTT_IRQ_PINS+1:0] raw
);
  localparam int NP = NTT_SEC1_PINS + NTT_SEC2_PINS;  // Plain pads

  // Power-up: tests off, pads at idle
  initial
  begin
    test_qualifier_n = 1'h1;
    {mode_select_a, mode_select_b, mode_select_c} = 3'h0;
    pci_bus_clock_in = 1'h0;
    raw = '0;
    raw[NP-1:0] = '1;
  end

  // Mode pins, held until changed
  task automatic mode(input logic q, a, b, c);
    @(posedge ref_clk);
    #1;
    {test_qualifier_n, mode_select_a, mode_select_b, mode_select_c} =
      {q, a, b, c};
  endtask : mode

  // Invert one chained pad
  task automatic flip(input int i);
    @(posedge ref_clk);
    #1;
    raw[i] = ~raw[i];
  endtask : flip

  // Clock pad level
  task automatic pclk(input logic v);
    @(posedge ref_clk);
    #1;
    pci_bus_clock_in = v;
  endtask : pclk

  // Wait out the propagation allowance before sampling
  task automatic settle();
    repeat (NTT_SETTLE_CYC + 1) @(posedge ref_clk);
    #2;
  endtask : settle
endmodule : ntt_ate_model
`default_nettype wire

/* dv/ntt_nand_tree_test_tb_top.sv */
// Purpose: Self-checking bench of the NAND tree and float test logic
// Assumes: Tester model drives pads, bench drives functional side
// Notes:   Chain expectations come from a local NAND fold
`timescale 1ns/1ps
`default_nettype none
module ntt_nand_tree_test_tb_top;
  import ntt_pkg::*;
  localparam int S1 = NTT_SEC1_PINS;
  localparam int NP = S1 + NTT_SEC2_PINS;
  localparam int NR = NP + NTT_IRQ_PINS + 2;
  logic ref_clk, rstn, test_qualifier_n, pci_bus_clock_in;
  logic mode_select_a, mode_select_b, mode_select_c;
  logic [NR-1:0] raw;
  logic [NP-1:0] func_pad_oe, pad_oe;
  logic func_dma_ack1_mid_chain_out_out, func_dma_ack1_mid_chain_out_oe, func_transceiver_dir_final_out_out, func_transceiver_dir_final_out_oe;
  logic dma_ack1_mid_chain_out, dma_ack1_oe, clk_path_active;
  logic transceiver_dir_final_out, transceiver_dir_oe;
  ntt_mode_t mode_status;
  int mismatches, n_tests;

  ntt_ate_model i_ntt_ate_model (.ref_clk, .test_qualifier_n,
    .mode_select_a, .mode_select_b, .mode_select_c, .pci_bus_clock_in,
    .raw);
  ntt_nand_tree_test i_ntt_nand_tree_test (.ref_clk, .rstn,
    .test_qualifier_n, .mode_select_a, .mode_select_b, .mode_select_c,
    .power_good_in(raw[NR-1]), .zero_wait_state_in_n(raw[NP]),
    .irq_in(raw[NR-2:NP+1]), .pci_bus_clock_in, .pad_in(raw[NP-1:0]),
    .func_pad_oe, .func_dma_ack1_mid_chain_out_out, .func_dma_ack1_mid_chain_out_oe, .func_transceiver_dir_final_out_out,
    .func_transceiver_dir_final_out_oe, .pad_oe, .dma_ack1_mid_chain_out, .dma_ack1_oe,
    .transceiver_dir_final_out, .transceiver_dir_oe, .clk_path_active,
    .mode_status);

  // Free-running 100 MHz clock
  initial
  begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Compare and count
  task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Reference NAND chain
  function automatic logic fold(logic s, logic [63:0] v, int n);
    for (int i = 0; i < n; i++) s = ~(s & v[i]);
    return s;
  endfunction : fold

  // Chain mode outputs against the reference
  task automatic chk_chain();
    logic mid;
    logic fin;
    mid = fold(1'h1, 64'({~mode_select_c, ~mode_select_b, ~mode_select_a,
      ~raw[NP], raw[S1-1:0]}), S1 + 4);
    fin = fold(mid, 64'({~raw[NR-1:NP+1], raw[NP-1:S1]}), NR - S1 - 1);
    chk("mid", dma_ack1_mid_chain_out, mid);
    chk("fin", transceiver_dir_final_out, fin);
    chk("oe", {pad_oe, dma_ack1_oe, transceiver_dir_oe}, 64'h3);
    chk("clk", clk_path_active, 1'h0);
  endtask : chk_chain

  // Qualifier high: functional values pass, clock path open
  task automatic t_normal();
    i_ntt_ate_model.mode(1'h1, 1'h0, 1'h0, 1'h0);
    i_ntt_ate_model.pclk(1'h1);
    i_ntt_ate_model.settle();
    chk("pad_oe", pad_oe, func_pad_oe);
    chk("obs", {dma_ack1_mid_chain_out, dma_ack1_oe, transceiver_dir_final_out,
      transceiver_dir_oe}, 4'hd);
    chk("clk", clk_path_active, 1'h1);
    chk("st", mode_status, NTT_MODE_NORMAL);
    $display("test normal done");
  endtask : t_normal

  // Both chain selects, then every chained pad but the three selects toggled alone
  task automatic t_nand();
    for (int k = 0; k < 2; k++)
    begin
      i_ntt_ate_model.mode(1'h0, k[0], 1'h0, ~k[0]);
      i_ntt_ate_model.settle();
      chk_chain();
      chk("st", mode_status, NTT_MODE_NAND);
    end
    // All three selects low keeps every inverted pad at its idle level
    i_ntt_ate_model.mode(1'h0, 1'h0, 1'h0, 1'h0);
    i_ntt_ate_model.settle();
    chk_chain();
    // Clock pad moves, chain must not follow
    i_ntt_ate_model.pclk(1'h0);
    i_ntt_ate_model.settle();
    chk_chain();
    for (int i = 0; i < NR; i++)
    begin
      i_ntt_ate_model.flip(i);
      i_ntt_ate_model.settle();
      chk_chain();
      i_ntt_ate_model.flip(i);
    end
    $display("test nand done");
  endtask : t_nand

  // Reset mid-run clears only the status
  task automatic t_reset();
    @(posedge ref_clk);
    #1 rstn = 1'h0;
    i_ntt_ate_model.settle();
    chk("st", mode_status, NTT_MODE_NORMAL);
    chk_chain();
    @(posedge ref_clk);
    #1 rstn = 1'h1;
    i_ntt_ate_model.settle();
    chk("st", mode_status, NTT_MODE_NAND);
    $display("test reset done");
  endtask : t_reset

  // All selects high: every pad released, observers too
  task automatic t_float();
    i_ntt_ate_model.mode(1'h0, 1'h1, 1'h1, 1'h1);
    i_ntt_ate_model.settle();
    chk("oe", {pad_oe, dma_ack1_oe, transceiver_dir_oe}, '0);
    chk("mid_out", dma_ack1_mid_chain_out, 1'h0);
    chk("fin_out", transceiver_dir_final_out, 1'h0);
    chk("st", mode_status, NTT_MODE_FLOAT);
    $display("test float done");
  endtask : t_float

  // Counts and verdict
  task automatic complete_run();
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  // Hang guard, well above the expected run length
  initial
  begin
    repeat (30000) @(posedge ref_clk);
    mismatches++;
    complete_run();
  end

  // Main sequence
  initial
  begin
    mismatches = 0;
    n_tests = 0;
    rstn = 1'h0;
    func_pad_oe = NP'(64'h5a5a_c3c3_a5a5_3c3c);
    {func_dma_ack1_mid_chain_out_out, func_dma_ack1_mid_chain_out_oe, func_transceiver_dir_final_out_out, func_transceiver_dir_final_out_oe} = 4'hd;
    repeat (12) @(posedge ref_clk);
    #1 rstn = 1'h1;
    t_normal();
    t_nand();
    t_reset();
    t_float();
    complete_run();
  end
endmodule : ntt_nand_tree_test_tb_top
`default_nettype wire
